// *** mgmt_master.sv ***
// far-side model: management master issuing register reads
`timescale 1ns/1ps
`default_nettype none

module mgmt_master (
	// clock
	input  wire logic       i_clk,
	// read wishes of the bench
	input  wire logic       i_req,
	input  wire logic [4:0] i_addr,
	// read port towards the register
	output logic            o_rd,
	output logic [4:0]      o_addr
);
	logic [4:0] last_q = 5'h00; // address of the previous read

	// idle address is the inverse of the last one, so no stale match;
	// a plain always keeps the declaration start value legal
	always @(posedge i_clk)
		if (i_req)
			last_q <= i_addr;
	assign o_rd   = i_req;
	assign o_addr = i_req ? i_addr : ~last_q;
endmodule : mgmt_master
`default_nettype wire

// *** phy_status_pkg.sv ***
// shared constants and types for the phy status summary register
package phy_status_pkg;

	// ************************************************************
	// management register addresses
	// ************************************************************
	localparam logic [4:0] ADDR_BASIC_STATUS  = 5'h01; // clears remote fault
	localparam logic [4:0] ADDR_AN_EXPANSION  = 5'h06; // clears page flag
	localparam logic [4:0] ADDR_STATUS_SUMMARY = 5'h10; // this register
	localparam logic [4:0] ADDR_FALSE_CARRIER = 5'h14; // clears false carrier
	localparam logic [4:0] ADDR_RX_ERROR      = 5'h15; // clears rx error
	localparam logic [4:0] ADDR_TENBASE_DFLT  = 5'h1F; // 10base reg, free choice

	// ************************************************************
	// bit positions inside the status summary word
	// ************************************************************
	localparam int BIT_RSVD_HI   = 15;
	localparam int BIT_XOVER     = 14;
	localparam int BIT_RX_ERR    = 13;
	localparam int BIT_POLARITY  = 12;
	localparam int BIT_FALSE_CAR = 11;
	localparam int BIT_SIG_DET   = 10;
	localparam int BIT_DESCR_LCK = 9;
	localparam int BIT_PAGE_RCV  = 8;
	localparam int BIT_RSVD_LO   = 7;
	localparam int BIT_REM_FAULT = 6;
	localparam int BIT_JABBER    = 5;
	localparam int BIT_AN_DONE   = 4;
	localparam int BIT_LOOPBACK  = 3;
	localparam int BIT_DUPLEX    = 2;
	localparam int BIT_SPEED10   = 1;
	localparam int BIT_LINK      = 0;

	localparam logic [15:0] WORD_RESET = 16'h0000; // read data after reset

	// ************************************************************
	// source signals from the transceiver core, same clock
	// ************************************************************
	typedef struct packed {
		logic auto_crossover_enable; // from phy_control_reg
		logic crossover_force;       // from phy_control_reg
		logic xover_live;            // current pair swap of the algorithm
		logic rx_error_evt;          // one-cycle receive error event
		logic polarity_inv;          // inverted polarity seen
		logic false_carrier_evt;     // one-cycle false carrier event
		logic signal_detect;         // unconditional signal detect level
		logic descr_lock;            // descrambler lock level
		logic page_rcvd_evt;         // link code word page received
		logic remote_fault_evt;      // partner reported remote fault
		logic jabber;                // lower-bit mirrors
		logic an_complete;
		logic loopback;
		logic duplex;
		logic speed10;
		logic link;
	} status_in_type;

	// ************************************************************
	// whole state of the block
	// ************************************************************
	typedef struct packed {
		logic        rx_err;       // latch high
		logic        polarity;     // mirror of the 10base flag
		logic        false_car;    // latch high
		logic        sig_det;      // latch low
		logic        descr_lck;    // latch low
		logic        page_rcv;     // mirror of expansion flag
		logic        rem_fault;    // sticky until basic status read
		logic [15:0] rd_data;      // read answer
		logic        rd_valid;     // read answer strobe
	} state_type;

endpackage : phy_status_pkg

// *** phy_status_summary.sv ***
// status summary register with its latched flags and read port
`timescale 1ns/1ps
`default_nettype none

module phy_status_summary #(
	parameter logic [4:0] TENBASE_ADDR = phy_status_pkg::ADDR_TENBASE_DFLT
) (
	// clock and reset
	input  wire logic                          I_SYS_CLK,
	input  wire logic                          I_ARST_N,
	// management read port
	input  wire logic                          I_MGMT_RD,
	input  wire logic [4:0]                    I_MGMT_ADDR,
	output logic      [15:0]                   O_RD_DATA,
	output logic                               O_RD_VALID,
	// status sources from the transceiver core
	input  wire phy_status_pkg::status_in_type I_STATUS
);

	// ************************************************************
	// helper functions
	// ************************************************************

	// read of a given address this cycle
	function automatic logic rd_hit(input logic rd, input logic [4:0] a,
		input logic [4:0] want);
		rd_hit = rd && (a == want);
	endfunction : rd_hit

	// crossover bit from the control settings
	function automatic logic xover_bit(input phy_status_pkg::status_in_type s);
		if (s.crossover_force)
			xover_bit = 1'b1;                        // forced swap
		else if (s.auto_crossover_enable)
			xover_bit = s.xover_live;                // live tracking
		else
			xover_bit = 1'b0;                        // normal pairs
	endfunction : xover_bit

	// ************************************************************
	// state and next state
	// ************************************************************
	phy_status_pkg::state_type st_q;   // registered state
	phy_status_pkg::state_type st_d;   // next state
	logic [15:0]               word;   // assembled summary word
	logic                      rd_sum; // summary register read
	logic                      rd_rx;  // rx error counter read
	logic                      rd_fc;  // false carrier counter read
	logic                      rd_tb;  // 10base register read
	logic                      rd_an;  // expansion register read
	logic                      rd_bs;  // basic status read

	// decode which register the master reads
	always_comb
	begin
		rd_sum = rd_hit(I_MGMT_RD, I_MGMT_ADDR,
			phy_status_pkg::ADDR_STATUS_SUMMARY);
		rd_rx  = rd_hit(I_MGMT_RD, I_MGMT_ADDR, phy_status_pkg::ADDR_RX_ERROR);
		rd_fc  = rd_hit(I_MGMT_RD, I_MGMT_ADDR,
			phy_status_pkg::ADDR_FALSE_CARRIER);
		rd_tb  = rd_hit(I_MGMT_RD, I_MGMT_ADDR, TENBASE_ADDR);
		rd_an  = rd_hit(I_MGMT_RD, I_MGMT_ADDR,
			phy_status_pkg::ADDR_AN_EXPANSION);
		rd_bs  = rd_hit(I_MGMT_RD, I_MGMT_ADDR,
			phy_status_pkg::ADDR_BASIC_STATUS);
	end

	// assemble the word as it stands before this read's side effects
	always_comb
	begin
		word = phy_status_pkg::WORD_RESET;
		word[phy_status_pkg::BIT_RSVD_HI]   = 1'b0;
		word[phy_status_pkg::BIT_RSVD_LO]   = 1'b0;
		word[phy_status_pkg::BIT_XOVER]     = xover_bit(I_STATUS);
		word[phy_status_pkg::BIT_RX_ERR]    = st_q.rx_err;
		word[phy_status_pkg::BIT_POLARITY]  = st_q.polarity;
		word[phy_status_pkg::BIT_FALSE_CAR] = st_q.false_car;
		word[phy_status_pkg::BIT_SIG_DET]   = st_q.sig_det;
		word[phy_status_pkg::BIT_DESCR_LCK] = st_q.descr_lck;
		word[phy_status_pkg::BIT_PAGE_RCV]  = st_q.page_rcv;
		word[phy_status_pkg::BIT_REM_FAULT] = st_q.rem_fault;
		word[phy_status_pkg::BIT_JABBER]    = I_STATUS.jabber;
		word[phy_status_pkg::BIT_AN_DONE]   = I_STATUS.an_complete;
		word[phy_status_pkg::BIT_LOOPBACK]  = I_STATUS.loopback;
		word[phy_status_pkg::BIT_DUPLEX]    = I_STATUS.duplex;
		word[phy_status_pkg::BIT_SPEED10]   = I_STATUS.speed10;
		word[phy_status_pkg::BIT_LINK]      = I_STATUS.link;
	end

	// next state: a new event always wins over a clearing read
	always_comb
	begin
		st_d = st_q;
		// latch high flags
		st_d.rx_err    = I_STATUS.rx_error_evt
			| (st_q.rx_err & ~rd_rx);
		st_d.false_car = I_STATUS.false_carrier_evt
			| (st_q.false_car & ~rd_fc);
		st_d.polarity  = I_STATUS.polarity_inv
			| (st_q.polarity & ~rd_tb);
		st_d.page_rcv  = I_STATUS.page_rcvd_evt
			| (st_q.page_rcv & ~rd_an);
		st_d.rem_fault = I_STATUS.remote_fault_evt
			| (st_q.rem_fault & ~rd_bs);
		// latch low: a summary read reloads the live level
		if (rd_sum)
		begin
			st_d.sig_det   = I_STATUS.signal_detect;
			st_d.descr_lck = I_STATUS.descr_lock;
		end
		else
		begin
			st_d.sig_det   = st_q.sig_det & I_STATUS.signal_detect;
			st_d.descr_lck = st_q.descr_lck & I_STATUS.descr_lock;
		end
		// read answer: only the summary address returns data
		st_d.rd_valid = I_MGMT_RD;
		if (rd_sum)
			st_d.rd_data = word;
		else
			st_d.rd_data = phy_status_pkg::WORD_RESET; // other addresses
	end

	// register the whole state
	always_ff @(posedge I_SYS_CLK or negedge I_ARST_N)
	begin
		if (!I_ARST_N)
		begin
			st_q           <= '0;
			st_q.rd_data   <= phy_status_pkg::WORD_RESET;
		end
		else
		begin
			st_q <= st_d;
		end
	end

	// outputs come straight from flip-flops
	assign O_RD_DATA  = st_q.rd_data;
	assign O_RD_VALID = st_q.rd_valid;

	// ************************************************************
	// assertions
	// ************************************************************

	a_rsvd_zero: assert property (@(posedge I_SYS_CLK) disable iff (!I_ARST_N)
		!O_RD_DATA[phy_status_pkg::BIT_RSVD_HI]
		&& !O_RD_DATA[phy_status_pkg::BIT_RSVD_LO])
		else $error("reserved bit read as one");

	a_xover_force: assert property (@(posedge I_SYS_CLK) disable iff (!I_ARST_N)
		(rd_sum && I_STATUS.crossover_force) |=>
		O_RD_DATA[phy_status_pkg::BIT_XOVER])
		else $error("forced crossover not reported");

	a_xover_live: assert property (@(posedge I_SYS_CLK) disable iff (!I_ARST_N)
		(rd_sum && !I_STATUS.crossover_force && I_STATUS.auto_crossover_enable)
		|=> O_RD_DATA[phy_status_pkg::BIT_XOVER]
		== $past(I_STATUS.xover_live))
		else $error("crossover bit not tracking");

	a_xover_off: assert property (@(posedge I_SYS_CLK) disable iff (!I_ARST_N)
		(rd_sum && !I_STATUS.crossover_force && !I_STATUS.auto_crossover_enable)
		|=> !O_RD_DATA[phy_status_pkg::BIT_XOVER])
		else $error("crossover set while disabled");

	a_rxerr_hold: assert property (@(posedge I_SYS_CLK) disable iff (!I_ARST_N)
		I_STATUS.rx_error_evt ##1 (!rd_rx)[*2] |=> st_q.rx_err)
		else $error("rx error flag lost");

	a_rxerr_clear: assert property (@(posedge I_SYS_CLK) disable iff (!I_ARST_N)
		(rd_rx && !I_STATUS.rx_error_evt) |=> !st_q.rx_err)
		else $error("rx error flag not cleared");

	a_polarity_rd: assert property (@(posedge I_SYS_CLK) disable iff (!I_ARST_N)
		(rd_sum && st_q.polarity) |=> st_q.polarity)
		else $error("summary read cleared polarity");

	a_fc_clear: assert property (@(posedge I_SYS_CLK) disable iff (!I_ARST_N)
		I_STATUS.false_carrier_evt |=> st_q.false_car ##1
		(st_q.false_car || $past(rd_fc)))
		else $error("false carrier flag wrong");

	a_sigdet_low: assert property (@(posedge I_SYS_CLK) disable iff (!I_ARST_N)
		(!I_STATUS.signal_detect && !rd_sum) ##1 !rd_sum
		|=> !st_q.sig_det)
		else $error("signal detect drop not held");

	a_lock_low: assert property (@(posedge I_SYS_CLK) disable iff (!I_ARST_N)
		(!I_STATUS.descr_lock && !rd_sum) |=> !st_q.descr_lck)
		else $error("descrambler lock drop not held");

	a_page_keep: assert property (@(posedge I_SYS_CLK) disable iff (!I_ARST_N)
		(st_q.page_rcv && !rd_an) |=> st_q.page_rcv)
		else $error("page flag dropped without expansion read");

	a_fault_clr: assert property (@(posedge I_SYS_CLK) disable iff (!I_ARST_N)
		(rd_bs && !I_STATUS.remote_fault_evt) |=> !st_q.rem_fault)
		else $error("remote fault not cleared");

	a_ll_reload: assert property (@(posedge I_SYS_CLK) disable iff (!I_ARST_N)
		rd_sum |=> st_q.sig_det == $past(I_STATUS.signal_detect))
		else $error("latch low not reloaded on read");

	a_low_bits: assert property (@(posedge I_SYS_CLK) disable iff (!I_ARST_N)
		rd_sum |=> O_RD_VALID && O_RD_DATA[phy_status_pkg::BIT_LINK]
		== $past(I_STATUS.link))
		else $error("summary read answer wrong");

endmodule : phy_status_summary

`default_nettype wire

// *** phy_status_summary_test.sv ***
// self-checking random bench for the status summary register
`timescale 1ns/1ps
`default_nettype none

module phy_status_summary_test;
	// ************************************************************
	// signals and expected state
	// ************************************************************
	logic                          clk;        // system clock
	logic                          rst_n;      // async reset
	logic                          req;        // read wanted
	logic [4:0]                    req_addr;   // address wanted
	logic                          rd;         // read strobe
	logic [4:0]                    ad;         // read address
	logic [15:0]                   rd_data;    // read answer
	logic                          rd_valid;   // answer strobe
	phy_status_pkg::status_in_type st;         // core sources
	logic [6:0]                    f;          // rx,pol,fc,sd,dl,pg,rf
	logic [15:0]                   exp_word;   // expected answer
	logic                          exp_valid;  // answer due
	int                            n_mismatch;
	int                            num_checks;
	int                            cycles;
	logic [4:0] tbl [6] = '{5'h01, 5'h06, 5'h10, 5'h14, 5'h15, 5'h1F};

	mgmt_master far (.i_clk(clk), .i_req(req), .i_addr(req_addr),
		.o_rd(rd), .o_addr(ad));
	phy_status_summary dut (.I_SYS_CLK(clk), .I_ARST_N(rst_n),
		.I_MGMT_RD(rd), .I_MGMT_ADDR(ad), .O_RD_DATA(rd_data),
		.O_RD_VALID(rd_valid), .I_STATUS(st));

	// ************************************************************
	// reference model, updated on the design's edge
	// ************************************************************
	function automatic logic clr(input logic [4:0] a);
		return rd && ad == a;
	endfunction : clr

	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			f = 7'h00;
			exp_valid = 1'b0;
		end
		else
		begin
			exp_valid = rd;
			// flags as before the read, crossover live
			exp_word = {1'b0, st.crossover_force |
				(st.auto_crossover_enable & st.xover_live),
				f[6:1], 1'b0, f[0], st[5:0]}
				& {16{ad == 5'h10}};
			f[6] = st.rx_error_evt | f[6] & !clr(5'h15);
			f[5] = st.polarity_inv | f[5] & !clr(5'h1F);
			f[4] = st.false_carrier_evt | f[4] & !clr(5'h14);
			f[3] = st.signal_detect & (f[3] | clr(5'h10));
			f[2] = st.descr_lock & (f[2] | clr(5'h10));
			f[1] = st.page_rcvd_evt | f[1] & !clr(5'h06);
			f[0] = st.remote_fault_evt | f[0] & !clr(5'h01);
		end
	end

	// ************************************************************
	// checking and driving
	// ************************************************************
	task automatic chk(input string name, input logic [15:0] got, exp);
		num_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	// one cycle: check last answer, then draw new inputs
	task automatic cycle(input logic evt_all);
		logic [31:0] r1;
		logic [31:0] r2;
		@(negedge clk);
		chk("valid", {15'h0, rd_valid}, {15'h0, exp_valid});
		if (exp_valid)
			chk("word", rd_data, exp_word);
		r1 = $urandom;
		r2 = $urandom;
		// events rare so that clearing reads are seen to work
		st = r1[15:0] & (r1[31:16] & r2[15:0] | 16'hE33F);
		if (evt_all)
			st = st | 16'h1CC0; // set must win over a clearing read
		req = r2[16];
		req_addr = r2[19:17] < 3'd6 ? tbl[r2[19:17]] : r2[24:20];
	endtask : cycle

	task automatic give_verdict();
		if (n_mismatch == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : give_verdict

	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// hang guard, well above the planned run
	initial cycles = 0;
	always @(posedge clk)
	begin
		cycles++;
		if (cycles > 5000)
		begin
			n_mismatch++;
			give_verdict();
		end
	end

	initial
	begin
		void'($urandom(32'hEDE3B647));
		n_mismatch = 0;
		num_checks = 0;
		st = '0;
		req = 1'b0;
		req_addr = 5'h00;
		rst_n = 1'b0;
		repeat (8) @(posedge clk);
		@(negedge clk) rst_n = 1'b1;
		repeat (3000) cycle(1'b0);
		repeat (40) cycle(1'b1);
		// reset in mid-run clears everything
		@(negedge clk) rst_n = 1'b0;
		#1 chk("reset", rd_data, 16'h0000);
		chk("reset valid", {15'h0, rd_valid}, 16'h0000);
		@(negedge clk) rst_n = 1'b1;
		repeat (60) cycle(1'b0);
		give_verdict();
	end
endmodule : phy_status_summary_test
`default_nettype wire
